// ==== include/ocp_pkg.sv ====
// package for the output compare unit
package ocp_pkg;
	// ==========================================
	// function select codes
	localparam logic [3:0] OCP_FN_OFF = 4'h0;
	localparam logic [3:0] OCP_FN_HIGH = 4'h1;
	localparam logic [3:0] OCP_FN_LOW = 4'h2;
	localparam logic [3:0] OCP_FN_TOGGLE = 4'h3;
	localparam logic [3:0] OCP_FN_DUAL = 4'h4;
	localparam logic [3:0] OCP_FN_PWM = 4'h5;
	localparam logic [3:0] OCP_FN_CENTER = 4'h6;
	localparam logic [3:0] OCP_FN_VFREQ = 4'h7;
	// ==========================================
	// widths and reset values
	localparam int OCP_WIDE = 32;
	localparam int OCP_NARROW = 16;
	localparam logic OCP_OUT_RESET = 1'b0;

	// ==========================================
	// control carrier
	typedef struct packed {
		logic [3:0] compare_function_select;
		logic wide_timer_select;
	} ocp_ctrl_t;

	typedef enum logic [1:0] {
		OCP_ST_IDLE = 2'b01,
		OCP_ST_RUN = 2'b10
	} ocp_state_t;

	typedef struct packed {
		ocp_state_t st;
		logic out;
		logic irq;
		logic [OCP_WIDE-1:0] cmp_a;
		logic [OCP_WIDE-1:0] cmp_b;
		logic [OCP_WIDE-1:0] acc;
		logic [OCP_WIDE-1:0] prev_timer;
	} ocp_state_s_t;
endpackage

// ==== logic/ocp_output_compare.sv ====
// output compare and pulse modes of a capture/compare timer channel
`timescale 1ns/1ps
module ocp_output_compare
	import ocp_pkg::*;
(
	// clock and reset
	input wire logic sys_clk_in,
	input wire logic reset_n_in,
	// control
	input wire ocp_ctrl_t ctrl_in,
	// timer and compare values
	input wire logic [OCP_WIDE-1:0] timer_count_in,
	input wire logic [OCP_WIDE-1:0] compare_a_in,
	input wire logic [OCP_WIDE-1:0] compare_b_in,
	// outputs
	output logic compare_out,
	output logic match_irq_out
);

	// ==========================================
	// state
	ocp_state_s_t s_q;
	ocp_state_s_t s_d;

	logic wide;
	logic [OCP_WIDE-1:0] mask;
	logic [OCP_WIDE-1:0] tmr;
	logic [OCP_WIDE-1:0] ca;
	logic [OCP_WIDE-1:0] cb;
	logic [OCP_WIDE-1:0] acc_sum;
	logic [3:0] fn;
	logic buffered;
	logic period_start;
	logic match_a;
	logic match_b;
	logic legal;
	logic single_edge;
	logic dual_edge;
	logic vfreq;
	logic narrow_only;
	logic set_evt;
	logic clr_evt;
	logic tgl_evt;
	logic carry;
	logic leave_run;
	logic [OCP_WIDE-1:0] acc_inc;
	logic [OCP_WIDE-1:0] prev_tmr;

	// ==========================================
	// function decode
	always_comb begin
		fn = ctrl_in.compare_function_select;
		wide = ctrl_in.wide_timer_select;
		single_edge = 1'b0;
		dual_edge = 1'b0;
		buffered = 1'b0;
		vfreq = 1'b0;
		narrow_only = 1'b0;
		case (fn)
			OCP_FN_HIGH, OCP_FN_LOW, OCP_FN_TOGGLE: begin
				single_edge = 1'b1;
			end
			OCP_FN_DUAL: begin
				dual_edge = 1'b1;
				narrow_only = 1'b1;
			end
			OCP_FN_PWM: begin
				dual_edge = 1'b1;
				buffered = 1'b1;
				narrow_only = 1'b1;
			end
			OCP_FN_CENTER: begin
				dual_edge = 1'b1;
				buffered = 1'b1;
				narrow_only = 1'b1;
			end
			OCP_FN_VFREQ: begin
				vfreq = 1'b1;
			end
			default: begin
				// off and unused codes compare nothing
				single_edge = 1'b0;
			end
		endcase
		// dual edge family refuses the wide timer
		legal = !(wide && narrow_only);
		leave_run = (fn == OCP_FN_OFF) || !legal;
		if (wide) begin
			mask = {OCP_WIDE{1'b1}};
		end else begin
			mask = {{OCP_NARROW{1'b0}}, {OCP_NARROW{1'b1}}};
		end
	end

	// ==========================================
	// period detect
	always_comb begin
		tmr = timer_count_in & mask;
		prev_tmr = s_q.prev_timer & mask;
		// timer wrapped or returned to zero: new period
		period_start = (tmr == '0) || (tmr < prev_tmr);
	end

	// ==========================================
	// compare match
	always_comb begin
		ca = (buffered ? s_q.cmp_a : compare_a_in) & mask;
		cb = (buffered ? s_q.cmp_b : compare_b_in) & mask;
		match_a = (tmr == ca);
		match_b = dual_edge && (tmr == cb);
	end

	// ==========================================
	// phase accumulator
	always_comb begin
		acc_inc = compare_a_in & mask;
		acc_sum = (s_q.acc + acc_inc) & mask;
		carry = vfreq && (acc_sum < (s_q.acc & mask));
	end

	// ==========================================
	// event select
	always_comb begin
		set_evt = 1'b0;
		clr_evt = 1'b0;
		tgl_evt = 1'b0;
		if (single_edge) begin
			set_evt = match_a && (fn == OCP_FN_HIGH);
			clr_evt = match_a && (fn == OCP_FN_LOW);
			tgl_evt = match_a && (fn == OCP_FN_TOGGLE);
		end
		if (dual_edge) begin
			// second value wins if both coincide
			clr_evt = match_b;
			set_evt = match_a && !match_b;
		end
	end

	// ==========================================
	// mode logic
	always_comb begin
		s_d = s_q;
		s_d.prev_timer = timer_count_in;
		s_d.irq = 1'b0;
		if (buffered && period_start) begin
			s_d.cmp_a = compare_a_in;
			s_d.cmp_b = compare_b_in;
		end
		case (s_q.st)
			OCP_ST_IDLE: begin
				s_d.out = OCP_OUT_RESET;
				s_d.acc = '0;
				if (!leave_run) begin
					s_d.st = OCP_ST_RUN;
					s_d.cmp_a = compare_a_in;
					s_d.cmp_b = compare_b_in;
				end
			end
			OCP_ST_RUN: begin
				if (leave_run) begin
					s_d.st = OCP_ST_IDLE;
					s_d.out = OCP_OUT_RESET;
				end else if (vfreq) begin
					// phase accumulator: output is carry pulse
					s_d.acc = acc_sum;
					s_d.out = carry;
					s_d.irq = carry;
				end else if (set_evt) begin
					s_d.out = 1'b1;
					s_d.irq = 1'b1;
				end else if (clr_evt) begin
					s_d.out = 1'b0;
					s_d.irq = 1'b1;
				end else if (tgl_evt) begin
					s_d.out = ~s_q.out;
					s_d.irq = 1'b1;
				end else begin
					// no event or unused code: level holds
					s_d.out = s_q.out;
				end
			end
			default: begin
				s_d.st = OCP_ST_IDLE;
				s_d.out = OCP_OUT_RESET;
			end
		endcase
	end

	// ==========================================
	// state register
	always_ff @(posedge sys_clk_in or negedge reset_n_in) begin
		if (!reset_n_in) begin
			s_q <= '{
				st: OCP_ST_IDLE,
				out: OCP_OUT_RESET,
				irq: 1'b0,
				cmp_a: '0,
				cmp_b: '0,
				acc: '0,
				prev_timer: '0
			};
		end else begin
			s_q <= s_d;
		end
	end

	// ==========================================
	// outputs
	assign compare_out = s_q.out;
	assign match_irq_out = s_q.irq;

endmodule // ocp_output_compare

// ==== verification/ocp_output_compare_props.sv ====
// checker for the output compare unit
`timescale 1ns/1ps
module ocp_props
	import ocp_pkg::*;
(
	input wire logic sys_clk_in,
	input wire logic reset_n_in,
	input wire ocp_ctrl_t ctrl_in,
	input wire logic [OCP_WIDE-1:0] timer_count_in,
	input wire logic [OCP_WIDE-1:0] compare_a_in,
	input wire logic [OCP_WIDE-1:0] compare_b_in,
	input wire logic compare_out,
	input wire logic match_irq_out
);
	// ========
	// helpers
	wire logic [3:0] f = ctrl_in.compare_function_select;
	wire logic w = ctrl_in.wide_timer_select;
	wire logic [31:0] t = timer_count_in;
	wire logic ha = w ? t == compare_a_in : t[15:0] == compare_a_in[15:0];
	wire logic hb = t[15:0] == compare_b_in[15:0];
	wire logic q = match_irq_out;
	wire logic o = compare_out;
	default clocking @(posedge sys_clk_in); endclocking
	default disable iff (!reset_n_in);
	property p_high; q && f == 1 |-> o; endproperty
	a_high: assert property (p_high) else $error("high");
	property p_low; q && f == 2 |-> !o; endproperty
	a_low: assert property (p_low) else $error("low");
	property p_tog; q && f == 3 |-> o != $past(o); endproperty
	a_tog: assert property (p_tog) else $error("toggle");
	property p_cause; q && f inside {[1:3]} |-> $past(ha); endproperty
	a_cause: assert property (p_cause) else $error("cause");
	property p_dlo; f == 4 && $past(hb) |-> !o; endproperty
	a_dlo: assert property (p_dlo) else $error("dual");
	property p_ref; w && f inside {[4:6]} |-> !o && !q; endproperty
	a_ref: assert property (p_ref) else $error("refuse");
	property p_off; f == 0 |-> !o && !q; endproperty
	a_off: assert property (p_off) else $error("off");
	property p_vf; f == 7 && o |-> q; endproperty
	a_vf: assert property (p_vf) else $error("vfreq");
	cover property (f == 3 && q);
	cover property (f == 5 && $fell(o));
	cover property (f == 7 && q);
endmodule // ocp_props
bind ocp_output_compare ocp_props i_props (.*);

// ==== verification/ocp_pin_load.sv ====
// load on the compare pin, counts rising edges
`timescale 1ns/1ps
module ocp_pin_load (
	input wire logic pin_in,
	output int rises_out
);
	initial rises_out = 0;
	always @(posedge pin_in) rises_out++;
endmodule // ocp_pin_load

// ==== verification/tb_ocp_output_compare.sv ====
// bench for the output compare unit
`timescale 1ns/1ps
module tb_ocp_output_compare;
	import ocp_pkg::*;
	logic sys_clk_in = 0, reset_n_in = 0, compare_out, match_irq_out;
	ocp_ctrl_t ctrl_in = '0;
	logic [31:0] timer_count_in = '0, compare_a_in = '0, compare_b_in = '0;
	int n_fail = 0, n_compared = 0, cyc = 0, hits, rises, r;
	always #5 sys_clk_in = ~sys_clk_in;
	ocp_output_compare i_dut (.*);
	ocp_pin_load i_load (.pin_in(compare_out), .rises_out(rises));
	// ========
	// tasks
	task check(string n, logic [31:0] s, e);
		n_compared++;
		if (s !== e) begin
			$display("wrong value %s exp %h seen %h", n, e, s);
			n_fail++;
		end
	endtask
	task start(int fn, logic w, logic [31:0] a, b);
		@(posedge sys_clk_in);
		reset_n_in <= 0;
		ctrl_in <= '{fn[3:0], w};
		{compare_a_in, compare_b_in, timer_count_in} <= {a, b, 32'h0};
		hits = 0;
		repeat (20) @(posedge sys_clk_in);
		reset_n_in <= 1;
		repeat (3) @(posedge sys_clk_in);
	endtask
	task sweep(int n);
		repeat (n) begin
			@(posedge sys_clk_in);
			timer_count_in <= timer_count_in + 32'h1;
			#1 if (match_irq_out === 1'b1) hits++;
		end
	endtask
	task t_edge;
		for (int i = 1; i < 4; i++) begin
			start(i, 0, 32'h0001_0005, 0);
			sweep(20);
			check("out", compare_out, i != 2);
			check("irq", hits, 1);
		end
		start(1, 0, 32'h5, 0);
		sweep(8);
		check("high", compare_out, 1);
		@(posedge sys_clk_in);
		ctrl_in <= '{OCP_FN_LOW, 1'b0};
		compare_a_in <= 32'hc;
		sweep(8);
		check("low", compare_out, 0);
		check("irq2", hits, 2);
		start(1, 1, 32'h0001_0005, 0);
		sweep(20);
		check("wide", hits, 0);
		check("wide out", compare_out, 0);
		$display("edge done");
	endtask
	task t_dual;
		for (int i = 4; i < 7; i++) begin
			start(i, 0, 4, 9);
			sweep(6);
			check("rise", compare_out, 1);
			sweep(6);
			check("fall", compare_out, 0);
			check("irq", hits, 2);
			start(i, 1, 4, 9);
			sweep(12);
			check("refuse", hits + compare_out, 0);
		end
		$display("dual done");
	endtask
	task t_buf;
		for (int i = 4; i < 6; i++) begin
			start(i, 0, 4, 9);
			sweep(6);
			@(posedge sys_clk_in);
			compare_b_in <= 32'h7;
			sweep(3);
			check("hold", compare_out, i == 5);
			@(posedge sys_clk_in);
			timer_count_in <= 32'h0;
			sweep(9);
			check("reload", compare_out, 0);
		end
		start(0, 0, 4, 9);
		sweep(12);
		check("off", hits + compare_out, 0);
		$display("buffer done");
	endtask
	task t_vf;
		start(7, 0, 32'h4000, 0);
		r = rises;
		sweep(17);
		check("vf16", hits, 4);
		check("pin", rises - r, 4);
		start(7, 1, 32'h4000_0000, 0);
		sweep(17);
		check("vf32", hits, 4);
		$display("vfreq done");
	endtask
	task stop_test;
		$display("compared %0d failed %0d", n_compared, n_fail);
		if (n_fail == 0 && n_compared > 0) $display("Regression OK");
		else $display("Regression broken");
		$finish;
	endtask
	always @(posedge sys_clk_in) begin
		if (++cyc > 3000) begin
			n_fail++;
			stop_test;
		end
	end
	initial begin
		t_edge;
		t_dual;
		t_buf;
		t_vf;
		stop_test;
	end
endmodule // tb_ocp_output_compare
